// ### pmm_pkg.sv
// constants, types and decoders shared by the management serial master
// assumes one 100 MHz clock and a plain strobe register port
package pmm_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_IRQ = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 4'hc;
	localparam int DIV_HI = 23;
	localparam int DIV_LO = 20;
	localparam int ALWAYS_BIT = 19;
	localparam int PRESUP_BIT = 18;
	localparam int BUSY_BIT = 17;
	localparam int WRITE_BIT = 16;
	localparam int PHY_HI = 12;
	localparam int PHY_LO = 8;
	localparam int REG_HI = 4;
	localparam int REG_LO = 0;
	localparam logic [31:0] CMD_RESET = 32'h0090_0000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [5:0] PRE_BITS = 6'h20;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [5:0] TA_POS = 6'h0e;
	localparam logic [5:0] DATA_POS = 6'h10;
	localparam logic [1:0] START_CODE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [1:0] TA_READ = 2'h0;

	typedef enum logic [1:0] {
		PMM_IDLE,
		PMM_PRE,
		PMM_SHIFT
	} pmm_state_e;

	// half of the MDC period in bus clocks
	function automatic logic [4:0] pmm_half(input logic [3:0] code);
		case (code)
			4'h0: pmm_half = 5'h02;
			4'h1: pmm_half = 5'h03;
			4'h2: pmm_half = 5'h04;
			4'h3: pmm_half = 5'h06;
			4'h4: pmm_half = 5'h08;
			4'h5: pmm_half = 5'h0a;
			4'h6: pmm_half = 5'h0c;
			4'h7: pmm_half = 5'h0e;
			4'h8: pmm_half = 5'h0f;
			4'h9: pmm_half = 5'h10;
			4'ha: pmm_half = 5'h12;
			4'hb: pmm_half = 5'h14;
			4'hc: pmm_half = 5'h16;
			4'hd: pmm_half = 5'h18;
			4'he: pmm_half = 5'h1b;
			default: pmm_half = 5'h1e;
		endcase
	endfunction
endpackage

// ### pmm_mdc_gen.sv
// MDC divider with registered rise and fall pulses
// assumes run and div come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module pmm_mdc_gen (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic run,
	input wire logic [3:0] div,
	output logic mdc,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic [4:0] cnt;
		logic mdc;
		logic rise;
		logic fall;
	} pmm_gen_s;

	pmm_gen_s r_reg;
	pmm_gen_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.rise = 1'b0;
		r_next.fall = 1'b0;
		if (!run) begin
			r_next.cnt = 5'h00;
			r_next.mdc = 1'b0;
		end else if (r_reg.cnt + 5'h01 >= pmm_pkg::pmm_half(div)) begin
			r_next.cnt = 5'h00;
			r_next.mdc = ~r_reg.mdc;
			r_next.rise = ~r_reg.mdc;
			r_next.fall = r_reg.mdc;
		end else begin
			r_next.cnt = r_reg.cnt + 5'h01;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign mdc = r_reg.mdc;
	assign rise = r_reg.rise;
	assign fall = r_reg.fall;

	logic [6:0] gap_reg;
	logic seen_reg;
	logic [3:0] div_seen_reg;
	// a divider change restarts the period check so a partial period is never judged
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap_reg <= 7'h00;
			seen_reg <= 1'b0;
			div_seen_reg <= 4'h0;
		end else if (ce) begin
			gap_reg <= r_reg.rise ? 7'h01 : gap_reg + 7'h01;
			seen_reg <= run && (div == div_seen_reg) && (seen_reg || r_reg.rise);
			div_seen_reg <= div;
		end
	end

	a_mdc_period: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && run && rise && seen_reg && $stable(div) && $past(ce))
		|-> gap_reg == {1'b0, pmm_pkg::pmm_half(div), 1'b0})
		else $error("mdc period does not match divider code");

	a_mdc_stop: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && !run) |=> (!mdc && !rise && !fall))
		else $error("mdc toggles while not running");
endmodule
`default_nettype wire

// ### pmm_master.sv
// management serial master: command registers, frame shifter, interrupt
// assumes a single-cycle strobe register port and an external PHY on MDC/MDIO
`timescale 1ns/1ps
`default_nettype none
module pmm_master (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [pmm_pkg::ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	output logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe
);
	typedef struct packed {
		pmm_pkg::pmm_state_e state;
		logic [3:0] div;
		logic always_on;
		logic pre_sup;
		logic busy;
		logic is_write;
		logic [4:0] phy;
		logic [4:0] regsel;
		logic [15:0] data;
		logic [31:0] frame;
		logic [15:0] rx;
		logic [5:0] cnt;
		logic mdio_o;
		logic mdio_oe;
		logic status;
		logic mask;
		logic irq;
		logic [31:0] rdata;
		logic sync1;
		logic sync2;
	} pmm_main_s;

	pmm_main_s r_reg;
	pmm_main_s r_next;
	logic mdc_rise;
	logic mdc_fall;
	logic mdc_run;
	logic start;
	logic done;

	localparam pmm_main_s RESET_VAL = '{
		state: pmm_pkg::PMM_IDLE,
		div: pmm_pkg::CMD_RESET[pmm_pkg::DIV_HI:pmm_pkg::DIV_LO],
		always_on: pmm_pkg::CMD_RESET[pmm_pkg::ALWAYS_BIT],
		pre_sup: pmm_pkg::CMD_RESET[pmm_pkg::PRESUP_BIT],
		busy: pmm_pkg::CMD_RESET[pmm_pkg::BUSY_BIT],
		is_write: pmm_pkg::CMD_RESET[pmm_pkg::WRITE_BIT],
		phy: pmm_pkg::CMD_RESET[pmm_pkg::PHY_HI:pmm_pkg::PHY_LO],
		regsel: pmm_pkg::CMD_RESET[pmm_pkg::REG_HI:pmm_pkg::REG_LO],
		data: pmm_pkg::DATA_RESET,
		default: '0
	};

	// the clock runs for a frame or whenever held on
	assign mdc_run = r_reg.busy || r_reg.always_on;

	pmm_mdc_gen u_gen (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.run(mdc_run),
		.div(r_reg.div),
		.mdc(mdc),
		.rise(mdc_rise),
		.fall(mdc_fall)
	);

	function automatic logic [31:0] cmd_word(input pmm_main_s s);
		cmd_word = '0;
		cmd_word[pmm_pkg::DIV_HI:pmm_pkg::DIV_LO] = s.div;
		cmd_word[pmm_pkg::ALWAYS_BIT] = s.always_on;
		cmd_word[pmm_pkg::PRESUP_BIT] = s.pre_sup;
		cmd_word[pmm_pkg::BUSY_BIT] = s.busy;
		cmd_word[pmm_pkg::WRITE_BIT] = s.is_write;
		cmd_word[pmm_pkg::PHY_HI:pmm_pkg::PHY_LO] = s.phy;
		cmd_word[pmm_pkg::REG_HI:pmm_pkg::REG_LO] = s.regsel;
	endfunction

	always_comb begin
		r_next = r_reg;
		start = 1'b0;
		done = 1'b0;
		r_next.sync1 = mdio_in;
		r_next.sync2 = r_reg.sync1;
		r_next.rdata = '0;

		// register writes; command writes are ignored while a frame runs
		if (wr) begin
			case (addr)
				pmm_pkg::ADDR_CMD: begin
					if (!r_reg.busy) begin
						r_next.div = wdata[pmm_pkg::DIV_HI:pmm_pkg::DIV_LO];
						r_next.always_on = wdata[pmm_pkg::ALWAYS_BIT];
						r_next.pre_sup = wdata[pmm_pkg::PRESUP_BIT];
						r_next.is_write = wdata[pmm_pkg::WRITE_BIT];
						r_next.phy = wdata[pmm_pkg::PHY_HI:pmm_pkg::PHY_LO];
						r_next.regsel = wdata[pmm_pkg::REG_HI:pmm_pkg::REG_LO];
						start = wdata[pmm_pkg::BUSY_BIT];
					end
				end
				pmm_pkg::ADDR_DATA: begin
					r_next.data = wdata[15:0];
				end
				pmm_pkg::ADDR_MASK: begin
					r_next.mask = wdata[0];
				end
				default: begin
				end
			endcase
		end

		// register reads; reading status clears it
		if (rd) begin
			case (addr)
				pmm_pkg::ADDR_CMD: begin
					r_next.rdata = cmd_word(r_reg);
				end
				pmm_pkg::ADDR_DATA: begin
					r_next.rdata = {16'h0000, r_reg.data};
				end
				pmm_pkg::ADDR_IRQ: begin
					r_next.rdata = {31'h0, r_reg.status};
					r_next.status = 1'b0;
				end
				pmm_pkg::ADDR_MASK: begin
					r_next.rdata = {31'h0, r_reg.mask};
				end
				default: begin
					r_next.rdata = '0;
				end
			endcase
		end

		// launch: latch the whole frame so later writes cannot disturb it
		if (start) begin
			r_next.busy = 1'b1;
			r_next.cnt = '0;
			r_next.frame = {pmm_pkg::START_CODE,
				wdata[pmm_pkg::WRITE_BIT] ? pmm_pkg::OP_WRITE : pmm_pkg::OP_READ,
				wdata[pmm_pkg::PHY_HI:pmm_pkg::PHY_LO],
				wdata[pmm_pkg::REG_HI:pmm_pkg::REG_LO],
				wdata[pmm_pkg::WRITE_BIT] ? pmm_pkg::TA_WRITE : pmm_pkg::TA_READ,
				(addr == pmm_pkg::ADDR_DATA) ? wdata[15:0] : r_reg.data};
			if (wdata[pmm_pkg::PRESUP_BIT]) begin
				r_next.state = pmm_pkg::PMM_SHIFT;
			end else begin
				r_next.state = pmm_pkg::PMM_PRE;
			end
		end

		case (r_reg.state)
			pmm_pkg::PMM_IDLE: begin
				r_next.mdio_oe = 1'b0;
				r_next.mdio_o = 1'b0;
			end
			pmm_pkg::PMM_PRE: begin
				if (mdc_fall) begin
					r_next.mdio_o = 1'b1;
					r_next.mdio_oe = 1'b1;
					if (r_reg.cnt == pmm_pkg::PRE_BITS - 6'h01) begin
						r_next.cnt = '0;
						r_next.state = pmm_pkg::PMM_SHIFT;
					end else begin
						r_next.cnt = r_reg.cnt + 6'h01;
					end
				end
			end
			pmm_pkg::PMM_SHIFT: begin
				if (mdc_fall) begin
					if (r_reg.cnt == pmm_pkg::FRAME_BITS) begin
						r_next.mdio_oe = 1'b0;
						r_next.mdio_o = 1'b0;
						r_next.state = pmm_pkg::PMM_IDLE;
						r_next.busy = 1'b0;
						done = 1'b1;
						if (!r_reg.is_write) begin
							r_next.data = r_reg.rx;
						end
					end else begin
						r_next.mdio_o = r_reg.frame[31];
						r_next.frame = {r_reg.frame[30:0], 1'b0};
						r_next.mdio_oe = r_reg.is_write || (r_reg.cnt < pmm_pkg::TA_POS);
						r_next.cnt = r_reg.cnt + 6'h01;
					end
				end else if (mdc_rise && !r_reg.is_write && r_reg.cnt > pmm_pkg::DATA_POS) begin
					r_next.rx = {r_reg.rx[14:0], r_reg.sync2};
				end
			end
			default: begin
				r_next.state = pmm_pkg::PMM_IDLE;
			end
		endcase

		// a completion in the same cycle as a status read stays set
		if (done) begin
			r_next.status = 1'b1;
		end
		r_next.irq = r_next.status && r_next.mask;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r_reg <= RESET_VAL;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign rdata = r_reg.rdata;
	assign irq = r_reg.irq;
	assign mdio_out = r_reg.mdio_o;
	assign mdio_oe = r_reg.mdio_oe;

	sequence s_frame_end;
		ce && r_reg.state == pmm_pkg::PMM_SHIFT && mdc_fall && r_reg.cnt == pmm_pkg::FRAME_BITS;
	endsequence

	sequence s_ta_fall;
		ce && r_reg.state == pmm_pkg::PMM_SHIFT && mdc_fall && r_reg.cnt == pmm_pkg::TA_POS;
	endsequence

	a_pre_skip: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && start && wdata[pmm_pkg::PRESUP_BIT]) |=> r_reg.state == pmm_pkg::PMM_SHIFT)
		else $error("preamble not skipped");

	a_pre_sent: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && start && !wdata[pmm_pkg::PRESUP_BIT])
		|=> r_reg.state == pmm_pkg::PMM_PRE && r_reg.cnt == 6'h00)
		else $error("preamble not started");

	a_busy_set: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && wr && addr == pmm_pkg::ADDR_CMD && wdata[pmm_pkg::BUSY_BIT] && !r_reg.busy)
		|=> r_reg.busy)
		else $error("busy did not set on launch");

	a_busy_clear: assert property (@(posedge clock) disable iff (!arst_n)
		s_frame_end |=> !r_reg.busy && r_reg.status && r_reg.state == pmm_pkg::PMM_IDLE)
		else $error("busy not cleared at frame end");

	a_read_release: assert property (@(posedge clock) disable iff (!arst_n)
		(s_frame_end ##0 !r_reg.is_write) or (s_ta_fall ##0 !r_reg.is_write)
		|=> !r_reg.mdio_oe)
		else $error("mdio driven during read turnaround");

	a_write_ta: assert property (@(posedge clock) disable iff (!arst_n)
		s_ta_fall ##0 r_reg.is_write |=> r_reg.mdio_oe && r_reg.mdio_o)
		else $error("write turnaround not one");

	a_mdio_edge: assert property (@(posedge clock) disable iff (!arst_n)
		$changed(r_reg.mdio_o) && r_reg.mdio_oe |-> $past(mdc_fall))
		else $error("mdio changed away from falling mdc");

	a_irq_level: assert property (@(posedge clock) disable iff (!arst_n)
		ce && done |=> r_reg.status ##0 (r_reg.irq == r_reg.mask))
		else $error("interrupt does not follow status and mask");

	sequence s_launch;
		ce && start;
	endsequence

	a_rdata_idle: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && !rd) |=> r_reg.rdata == 32'h0000_0000)
		else $error("read data outside the read answer cycle");

	a_cmd_locked: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && wr && addr == pmm_pkg::ADDR_CMD && r_reg.busy)
		|=> $stable(r_reg.phy) && $stable(r_reg.regsel) && $stable(r_reg.is_write))
		else $error("command fields changed while busy");

	a_data_load: assert property (@(posedge clock) disable iff (!arst_n)
		(s_frame_end ##0 !r_reg.is_write) |=> r_reg.data == $past(r_reg.rx))
		else $error("read result not stored in data register");

	a_write_oe: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && r_reg.state == pmm_pkg::PMM_SHIFT && r_reg.is_write && mdc_fall
		&& r_reg.cnt != pmm_pkg::FRAME_BITS) |=> r_reg.mdio_oe)
		else $error("write frame released the line early");

	a_pre_ones: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && r_reg.state == pmm_pkg::PMM_PRE && mdc_fall) |=> r_reg.mdio_o && r_reg.mdio_oe)
		else $error("preamble bit not a driven one");

	a_idle_quiet: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && r_reg.state == pmm_pkg::PMM_IDLE) |=> !r_reg.mdio_oe)
		else $error("line driven while idle");

	a_rx_edge: assert property (@(posedge clock) disable iff (!arst_n)
		$changed(r_reg.rx) |-> $past(mdc_rise))
		else $error("read bit taken away from rising mdc");

	a_busy_hold: assert property (@(posedge clock) disable iff (!arst_n)
		(r_reg.state != pmm_pkg::PMM_IDLE) |-> r_reg.busy)
		else $error("busy low while a frame runs");

	a_launch_op: assert property (@(posedge clock) disable iff (!arst_n)
		s_launch |=> r_reg.frame[31:30] == pmm_pkg::START_CODE
		&& r_reg.frame[29:28] == (r_reg.is_write ? pmm_pkg::OP_WRITE : pmm_pkg::OP_READ))
		else $error("start or opcode field wrong at launch");

	a_launch_phy: assert property (@(posedge clock) disable iff (!arst_n)
		s_launch |=> r_reg.frame[27:23] == r_reg.phy)
		else $error("phy address field wrong at launch");

	a_launch_reg: assert property (@(posedge clock) disable iff (!arst_n)
		s_launch |=> r_reg.frame[22:18] == r_reg.regsel)
		else $error("register address field wrong at launch");

	a_status_hold: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && r_reg.status && !(rd && addr == pmm_pkg::ADDR_IRQ)) |=> r_reg.status)
		else $error("status cleared without a status read");

	a_pre_count: assert property (@(posedge clock) disable iff (!arst_n)
		(r_reg.state == pmm_pkg::PMM_PRE) |-> r_reg.cnt < pmm_pkg::PRE_BITS)
		else $error("preamble count out of range");

	a_frame_count: assert property (@(posedge clock) disable iff (!arst_n)
		(r_reg.state == pmm_pkg::PMM_SHIFT) |-> r_reg.cnt <= pmm_pkg::FRAME_BITS)
		else $error("frame bit count out of range");

	a_shift_msb: assert property (@(posedge clock) disable iff (!arst_n)
		(ce && r_reg.state == pmm_pkg::PMM_SHIFT && mdc_fall && r_reg.cnt != pmm_pkg::FRAME_BITS)
		|=> r_reg.mdio_o == $past(r_reg.frame[31]))
		else $error("frame bit not sent most significant first");
endmodule
`default_nettype wire

// ### pmm_phy_model.sv
// behavioural PHY on the management pins: captures frames, answers reads
// assumes a pulled-up shared MDIO wire built by the bench
`timescale 1ns/1ps
`default_nettype none
module pmm_phy_model (
	input wire logic arst_n,
	input wire logic mdc,
	input wire logic mdio,
	input wire logic host_oe,
	output logic phy_out,
	output logic phy_oe,
	output logic [31:0] frame,
	output logic [7:0] pre_ones
);
	logic in_frame;
	logic prev;
	logic [5:0] cnt;
	logic [7:0] ones;
	logic [15:0] rd_val;
	assign rd_val = 16'hc0de ^ {11'h000, frame[22:18]};
	always_ff @(posedge mdc or negedge arst_n) begin
		if (!arst_n) begin
			in_frame <= 1'b0;
			prev <= 1'b1;
			cnt <= 6'h00;
			ones <= 8'h00;
			phy_out <= 1'b0;
			phy_oe <= 1'b0;
			frame <= 32'h0000_0000;
			pre_ones <= 8'h00;
		end else if (!in_frame) begin
			if (!host_oe) begin
				prev <= 1'b1;
				ones <= 8'h00;
			end else if (prev == 1'b0 && mdio == 1'b1) begin
				in_frame <= 1'b1;
				cnt <= 6'h02;
				frame <= 32'h4000_0000;
				pre_ones <= ones;
			end else begin
				prev <= mdio;
				ones <= ones + {7'h00, mdio};
			end
		end else begin
			frame[6'h1f - cnt] <= mdio;
			cnt <= cnt + 6'h01;
			if (cnt == 6'h0e && frame[29:28] == 2'h2) begin
				phy_oe <= 1'b1;
				phy_out <= 1'b0;
			end else if (cnt >= 6'h0f && cnt < 6'h1f && phy_oe) begin
				phy_out <= rd_val[6'h1e - cnt];
			end
			if (cnt == 6'h1f) begin
				in_frame <= 1'b0;
				phy_oe <= 1'b0;
				prev <= 1'b1;
				ones <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// ### pmm_master_bench.sv
// self-checking bench for the management serial master
// assumes the PHY model and a pull-up on the MDIO wire
`timescale 1ns/1ps
`default_nettype none
module pmm_master_bench;
	logic clock, arst_n, ce, wr, rd, mdio_in, irq, mdc, mdio_out, mdio_oe;
	logic phy_out, phy_oe;
	logic [pmm_pkg::ADDR_W-1:0] addr;
	logic [31:0] wdata, rdata, got, frame;
	logic [7:0] pre_ones;
	logic [7:0] per [16] = '{8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
		8'h1e, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h36, 8'h3c};
	int n_mismatch, checked, n;
	time t0;
	assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
	pmm_master u_pmm_master (.clock(clock), .arst_n(arst_n), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
	pmm_phy_model u_pmm_phy_model (.arst_n(arst_n), .mdc(mdc), .mdio(mdio_in),
		.host_oe(mdio_oe), .phy_out(phy_out), .phy_oe(phy_oe), .frame(frame),
		.pre_ones(pre_ones));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] cmd(input logic [3:0] dv, input logic on, pre, go, wrt,
		input logic [4:0] ph, rg);
		return {8'h00, dv, on, pre, go, wrt, 3'h0, ph, 3'h0, rg};
	endfunction
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_idle;
		for (n = 0; n < 1000; n++) begin
			rd_reg(pmm_pkg::ADDR_CMD, got);
			if (got[pmm_pkg::BUSY_BIT] === 1'b0) break;
		end
		chk_val({31'h0, got[pmm_pkg::BUSY_BIT]}, 32'h0);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		arst_n = 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		rd_reg(pmm_pkg::ADDR_CMD, got);
		chk_val(got, 32'h0090_0000);
		rd_reg(pmm_pkg::ADDR_DATA, got);
		chk_val(got, 32'h0);
		rd_reg(pmm_pkg::ADDR_IRQ, got);
		chk_val(got, 32'h0);
		rd_reg(pmm_pkg::ADDR_MASK, got);
		chk_val(got, 32'h0);
		rd_reg(4'h2, got);
		chk_val(got, 32'h0);
		$display("test reset_values done");
		for (int i = 0; i < 16; i++) begin
			wr_reg(pmm_pkg::ADDR_CMD, cmd(i[3:0], 1'b1, 1'b0, 1'b0, 1'b0, 5'h00, 5'h00));
			@(posedge mdc);
			@(posedge mdc);
			t0 = $time;
			@(posedge mdc);
			chk_val(32'(($time - t0) / 10), {24'h0, per[i]});
		end
		$display("test divider_codes done");
		@(posedge clock);
		ce <= 1'b0;
		@(posedge clock);
		#1 got = {31'h0, mdc};
		n = 0;
		repeat (80) begin
			@(posedge clock);
			#1 if ({31'h0, mdc} !== got) n++;
		end
		chk_val(n, 0);
		@(posedge clock);
		ce <= 1'b1;
		$display("test clock_enable done");
		wr_reg(pmm_pkg::ADDR_CMD, cmd(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 5'h00));
		repeat (10) @(posedge clock);
		n = 0;
		repeat (100) begin
			@(posedge clock);
			if (mdc !== 1'b0 || mdio_oe !== 1'b0) n++;
		end
		chk_val(n, 0);
		$display("test clock_gating done");
		wr_reg(pmm_pkg::ADDR_MASK, 32'h1);
		wr_reg(pmm_pkg::ADDR_DATA, 32'h0000_3c5a);
		wr_reg(pmm_pkg::ADDR_CMD, cmd(4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 5'h15, 5'h0a));
		wr_reg(pmm_pkg::ADDR_CMD, cmd(4'h1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h01, 5'h01));
		wait_idle;
		rd_reg(pmm_pkg::ADDR_CMD, got);
		chk_val(got, cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 5'h15, 5'h0a));
		chk_val(frame, {2'h1, 2'h1, 5'h15, 5'h0a, 2'h2, 16'h3c5a});
		chk_val({24'h0, pre_ones}, 32'h0);
		rd_reg(pmm_pkg::ADDR_DATA, got);
		chk_val(got, 32'h0000_3c5a);
		chk_val({31'h0, irq}, 32'h1);
		rd_reg(pmm_pkg::ADDR_IRQ, got);
		chk_val(got, 32'h1);
		@(posedge clock);
		#1 chk_val({31'h0, irq}, 32'h0);
		rd_reg(pmm_pkg::ADDR_IRQ, got);
		chk_val(got, 32'h0);
		$display("test write_frame done");
		wr_reg(pmm_pkg::ADDR_MASK, 32'h0);
		wr_reg(pmm_pkg::ADDR_CMD, cmd(4'h2, 1'b1, 1'b0, 1'b1, 1'b0, 5'h03, 5'h1f));
		wait_idle;
		chk_val({24'h0, pre_ones}, 32'h20);
		chk_val({18'h0, frame[31:18]}, {18'h0, 2'h1, 2'h2, 5'h03, 5'h1f});
		rd_reg(pmm_pkg::ADDR_DATA, got);
		chk_val(got, 32'h0000_c0c1);
		chk_val({31'h0, irq}, 32'h0);
		rd_reg(pmm_pkg::ADDR_IRQ, got);
		chk_val(got, 32'h1);
		$display("test read_frame done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
